// ==== src/bats_pkg.sv ====
// Purpose: shared constants for the beam array analog teach scaler
// Assumes: 40 MHz system clock, millisecond tick for all slow timing
// Notes: counts above 4096 cycles are re-exposed as top parameters
package bats_pkg;
   // ***************************************************
   // clock and timing
   // ***************************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 1000;          // one timing tick, in us
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int LONG_HOLD_MS = 5000;     // long teach hold
   localparam int FLASH_PERIOD_MS = 3000;  // indicator pattern period
   localparam int FLASH_ON_MS = 250;       // one flash half, on or off
   localparam int DEBOUNCE_MS = 20;        // teach input settle time
   localparam int MS_W = 13;               // holds up to 8191 ms

   // ***************************************************
   // config_switch_bank bit positions
   // ***************************************************
   localparam int SW_VOLT = 0;     // 1: voltage output
   localparam int SW_SIZE = 1;     // 1: size mode, 0: position mode
   localparam int SW_REMOTE = 2;   // 1: remote teach enabled
   localparam int SW_DEFAULT = 7;  // 1: restore defaults at power-up

   // flash counts per period for each teach step
   localparam logic [1:0] FLASH_N_MIN = 2'h1;
   localparam logic [1:0] FLASH_N_MAX = 2'h2;
   localparam logic [1:0] FLASH_N_END = 2'h3;

   // ***************************************************
   // teach sequence states
   // ***************************************************
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_MIN = 4'h2,
      ST_MAX = 4'h4,
      ST_END = 4'h8
   } bats_state_t;
endpackage : bats_pkg

// ==== src/bats_scaler.sv ====
// Purpose: map interrupted beams to an analog level with teach control
// Assumes: beam inputs are synchronous; nv storage is outside, via ports
// Notes: power loss is modelled by rst_n; teach state is never kept
`timescale 1ns/1ps
module bats_scaler #(
   parameter int N_BEAMS = 64,
   parameter int BW = 8,
   parameter int CODE_W = 12,
   parameter int TICK_CYC = bats_pkg::TICK_CYC
) (
   input wire logic clk,                       // 40 MHz system clock
   input wire logic rst_n,                     // power-on reset
   input wire logic [N_BEAMS-1:0] beams_blocked, // 1: beam interrupted
   input wire logic [BW-1:0] array_len,        // beams in attached array
   input wire logic teach_button,              // 1: button pressed
   input wire logic remote_teach_in,           // 1: remote input on
   input wire logic [7:0] config_switch_bank,  // switch bank levels
   input wire logic [BW-1:0] nv_min_in,        // stored minimum reference
   input wire logic [BW-1:0] nv_max_in,        // stored maximum reference
   input wire logic [BW-1:0] nv_len_in,        // stored array length
   output logic [CODE_W-1:0] analog_code,      // 0: 4 mA/0 V, max: 20/10
   output logic analog_voltage_sel,            // 1: voltage output
   output logic out_interrupted_n,             // 0: beam cut (position mode: only inside taught min..max)
   output logic teach_indicator,               // indicator led
   output logic teach_last_step,               // steady: last teach step
   output logic nv_wr,                         // one-cycle store pulse
   output logic [BW-1:0] nv_min_out,           // reference to store
   output logic [BW-1:0] nv_max_out,           // reference to store
   output logic [BW-1:0] nv_len_out            // length to store
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam logic [CODE_W-1:0] CODE_MAX = '1;

   if (N_BEAMS < 2 || N_BEAMS >= (1 << BW) || TICK_CYC < 2) begin : g_chk
      $error("bats_scaler: parameters out of range");
   end

   // ***************************************************
   // helper functions
   // ***************************************************
   // position: highest blocked beam number; size: count of blocked beams
   function automatic logic [BW-1:0] beam_value(
         input logic [N_BEAMS-1:0] b, input logic size);
      logic [BW-1:0] v;
      v = '0;
      for (int i = 0; i < N_BEAMS; i++) begin
         if (b[i]) begin
            v = size ? BW'(v + 1'b1) : BW'(i + 1);
         end
      end
      return v;
   endfunction : beam_value

   // linear scale of val between mn and mx; mn > mx gives falling slope
   function automatic logic [CODE_W-1:0] scale(
         input logic [BW-1:0] val, input logic [BW-1:0] mn,
         input logic [BW-1:0] mx);
      logic signed [BW+1:0] num;
      logic signed [BW+1:0] den;
      logic signed [BW+CODE_W+2:0] q;
      num = $signed({2'b00, val}) - $signed({2'b00, mn});
      den = $signed({2'b00, mx}) - $signed({2'b00, mn});
      q = '0;
      if (den != '0) begin
         q = (num * $signed({1'b0, CODE_MAX})) / den;
      end
      if (q <= 0) begin
         return '0;
      end else if (q >= $signed({{(BW+3){1'b0}}, CODE_MAX})) begin
         return CODE_MAX;
      end
      return q[CODE_W-1:0];
   endfunction : scale

   // any blocked beam whose number lies within lo..hi
   function automatic logic in_range(input logic [N_BEAMS-1:0] b,
         input logic [BW-1:0] lo, input logic [BW-1:0] hi);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_BEAMS; i++) begin
         if (b[i] && BW'(i + 1) >= lo && BW'(i + 1) <= hi) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : in_range

   // ***************************************************
   // teach input timing
   // ***************************************************
   logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
   logic [bats_pkg::MS_W-1:0] db_cnt_reg, db_cnt_next;
   logic [bats_pkg::MS_W-1:0] hold_reg, hold_next;
   logic db_reg, db_next;
   logic remote_en_reg;
   logic tick, raw, long_ev, short_ev;

   // ms divider, debounce, and brief/long classification
   always_comb begin
      tick = (tick_cnt_reg == TW'(TICK_CYC - 1));
      tick_cnt_next = tick ? '0 : TW'(tick_cnt_reg + 1'b1);
      raw = teach_button | (remote_en_reg & remote_teach_in);
      db_next = db_reg;
      db_cnt_next = db_cnt_reg;
      if (raw == db_reg) begin
         db_cnt_next = '0;
      end else if (tick) begin
         if (db_cnt_reg == bats_pkg::MS_W'(bats_pkg::DEBOUNCE_MS - 1)) begin
            db_next = raw;
            db_cnt_next = '0;
         end else begin
            db_cnt_next = db_cnt_reg + 1'b1;
         end
      end
      hold_next = hold_reg;
      if (!db_reg) begin
         hold_next = '0;
      end else if (tick &&
            hold_reg != bats_pkg::MS_W'(bats_pkg::LONG_HOLD_MS)) begin
         hold_next = hold_reg + 1'b1;
      end
      // long fires once while held, so the led answers before release
      long_ev = db_reg && tick &&
         hold_reg == bats_pkg::MS_W'(bats_pkg::LONG_HOLD_MS - 1);
      short_ev = db_reg && !db_next &&
         hold_reg != bats_pkg::MS_W'(bats_pkg::LONG_HOLD_MS);
   end

   // timing registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
         db_cnt_reg <= '0;
         hold_reg <= '0;
         db_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         db_cnt_reg <= db_cnt_next;
         hold_reg <= hold_next;
         db_reg <= db_next;
      end
   end

   // ***************************************************
   // boot, teach sequence, scaling and outputs
   // ***************************************************
   bats_pkg::bats_state_t st_reg, st_next;
   logic booted_reg, booted_next;
   logic volt_reg, volt_next, size_reg, size_next, remote_en_next;
   logic [BW-1:0] len_reg, len_next;
   logic [BW-1:0] act_min_reg, act_min_next, act_max_reg, act_max_next;
   logic [BW-1:0] ses_min_reg, ses_min_next, ses_max_reg, ses_max_next;
   logic [bats_pkg::MS_W-1:0] ph_reg, ph_next;
   logic [CODE_W-1:0] code_reg, code_next;
   logic int_n_reg, int_n_next, led_reg, led_next;
   logic last_reg, last_next, wr_reg, wr_next;
   logic [BW-1:0] use_min, use_max, val, lo, hi;
   logic [1:0] nflash;
   logic [bats_pkg::MS_W-1:0] slot;

   always_comb begin
      st_next = st_reg;
      booted_next = 1'b1;
      volt_next = volt_reg;
      size_next = size_reg;
      remote_en_next = remote_en_reg;
      len_next = len_reg;
      act_min_next = act_min_reg;
      act_max_next = act_max_reg;
      ses_min_next = ses_min_reg;
      ses_max_next = ses_max_reg;
      wr_next = 1'b0;
      // switches are caught once after power-up and then held
      if (!booted_reg) begin
         volt_next = config_switch_bank[bats_pkg::SW_VOLT];
         size_next = config_switch_bank[bats_pkg::SW_SIZE];
         remote_en_next = config_switch_bank[bats_pkg::SW_REMOTE];
         len_next = array_len;
         if (config_switch_bank[bats_pkg::SW_DEFAULT] ||
               nv_len_in != array_len) begin
            act_min_next = '0;
            act_max_next = array_len;
            wr_next = 1'b1;
         end else begin
            act_min_next = nv_min_in;
            act_max_next = nv_max_in;
         end
      end else if (array_len != len_reg) begin
         // a swapped array cancels teach and rescales to its length
         len_next = array_len;
         act_min_next = '0;
         act_max_next = array_len;
         wr_next = 1'b1;
         st_next = bats_pkg::ST_RUN;
      end else begin
         case (st_reg)
            bats_pkg::ST_RUN: begin
               if (long_ev) begin
                  st_next = bats_pkg::ST_MIN;
                  ses_min_next = act_min_reg;
                  ses_max_next = act_max_reg;
               end
            end
            bats_pkg::ST_MIN: begin
               if (short_ev) begin
                  ses_min_next = beam_value(beams_blocked, size_reg);
                  st_next = bats_pkg::ST_MAX;
               end
            end
            bats_pkg::ST_MAX: begin
               if (short_ev) begin
                  ses_max_next = beam_value(beams_blocked, size_reg);
                  st_next = bats_pkg::ST_END;
               end
            end
            bats_pkg::ST_END: begin
               if (long_ev) begin
                  act_min_next = ses_min_reg;
                  act_max_next = ses_max_reg;
                  wr_next = 1'b1;
                  st_next = bats_pkg::ST_RUN;
               end else if (short_ev) begin
                  st_next = bats_pkg::ST_RUN;
               end
            end
            default: st_next = bats_pkg::ST_RUN;
         endcase
      end

      // flash pattern: n flashes at the start of each period
      case (st_reg)
         bats_pkg::ST_MIN: nflash = bats_pkg::FLASH_N_MIN;
         bats_pkg::ST_MAX: nflash = bats_pkg::FLASH_N_MAX;
         bats_pkg::ST_END: nflash = bats_pkg::FLASH_N_END;
         default: nflash = 2'h0;
      endcase
      ph_next = ph_reg;
      if (st_next != st_reg || nflash == 2'h0) begin
         ph_next = '0;
      end else if (tick) begin
         ph_next = (ph_reg ==
            bats_pkg::MS_W'(bats_pkg::FLASH_PERIOD_MS - 1)) ? '0 :
            ph_reg + 1'b1;
      end
      slot = ph_reg / bats_pkg::MS_W'(bats_pkg::FLASH_ON_MS);
      led_next = !slot[0] &&
         slot < bats_pkg::MS_W'({nflash, 1'b0});
      last_next = (st_next == bats_pkg::ST_END);

      // live scaling with session refs while teaching
      use_min = (st_reg == bats_pkg::ST_RUN) ? act_min_reg : ses_min_reg;
      use_max = (st_reg == bats_pkg::ST_RUN) ? act_max_reg : ses_max_reg;
      val = beam_value(beams_blocked, size_reg);
      code_next = booted_reg ? scale(val, use_min, use_max) : '0;
      lo = (use_min < use_max) ? use_min : use_max;
      hi = (use_min < use_max) ? use_max : use_min;
      if (!booted_reg) begin
         int_n_next = 1'b1;
      end else if (size_reg) begin
         int_n_next = !(|beams_blocked);
      end else begin
         int_n_next = !in_range(beams_blocked, lo, hi);
      end
   end

   // control and output registers; reset also aborts any teach
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= bats_pkg::ST_RUN;
         booted_reg <= 1'b0;
         volt_reg <= 1'b0;
         size_reg <= 1'b0;
         remote_en_reg <= 1'b0;
         len_reg <= '0;
         act_min_reg <= '0;
         act_max_reg <= '0;
         ses_min_reg <= '0;
         ses_max_reg <= '0;
         ph_reg <= '0;
         code_reg <= '0;
         int_n_reg <= 1'b1;
         led_reg <= 1'b0;
         last_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         booted_reg <= booted_next;
         volt_reg <= volt_next;
         size_reg <= size_next;
         remote_en_reg <= remote_en_next;
         len_reg <= len_next;
         act_min_reg <= act_min_next;
         act_max_reg <= act_max_next;
         ses_min_reg <= ses_min_next;
         ses_max_reg <= ses_max_next;
         ph_reg <= ph_next;
         code_reg <= code_next;
         int_n_reg <= int_n_next;
         led_reg <= led_next;
         last_reg <= last_next;
         wr_reg <= wr_next;
      end
   end

   // outputs straight from registers
   assign analog_code = code_reg;
   assign analog_voltage_sel = volt_reg;
   assign out_interrupted_n = int_n_reg;
   assign teach_indicator = led_reg;
   assign teach_last_step = last_reg;
   assign nv_wr = wr_reg;
   assign nv_min_out = act_min_reg;
   assign nv_max_out = act_max_reg;
   assign nv_len_out = len_reg;
endmodule : bats_scaler

// ==== tb/bats_beam_model.sv ====
// Purpose: emitter and receiver beam pairs seen by the scaler
// Assumes: one object spans beams obj_lo..obj_hi, 0 means no object
// Notes: beams beyond the fitted length never report a cut
`timescale 1ns/1ps
module bats_beam_model #(
   parameter int N_BEAMS = 8
) (
   input wire logic [3:0] obj_lo, // lowest shaded beam, 0: none
   input wire logic [3:0] obj_hi, // highest shaded beam
   input wire logic [3:0] array_len, // beams fitted
   output logic [N_BEAMS-1:0] beams_blocked // 1: beam cut
);
   // a receiver sees its beam cut where the object stands in the array
   always_comb begin
      for (int i = 0; i < N_BEAMS; i++) begin
         beams_blocked[i] = obj_lo != 4'h0 && i + 1 >= int'(obj_lo)
            && i + 1 <= int'(obj_hi) && i < int'(array_len);
      end
   end
endmodule : bats_beam_model

// ==== tb/bats_chk_sva.sv ====
// Purpose: port checks for the beam array analog teach scaler
// Assumes: one clock, switches held steady except where noted
// Notes: quiet counter marks time since any teach input activity
`timescale 1ns/1ps
module bats_chk #(
   parameter int N_BEAMS = 64,
   parameter int BW = 8,
   parameter int CODE_W = 12,
   parameter int TICK_CYC = 4
) (
   input wire logic clk, // clock
   input wire logic rst_n, // power-on reset
   input wire logic [N_BEAMS-1:0] beams_blocked, // beams cut
   input wire logic [BW-1:0] array_len, // fitted length
   input wire logic teach_button, // button
   input wire logic remote_teach_in, // remote teach
   input wire logic [7:0] config_switch_bank, // switches
   input wire logic [CODE_W-1:0] analog_code, // level
   input wire logic analog_voltage_sel, // voltage mode
   input wire logic out_interrupted_n, // discrete
   input wire logic teach_indicator, // led
   input wire logic teach_last_step, // last step
   input wire logic nv_wr, // store pulse
   input wire logic [BW-1:0] nv_len_out // stored length
);
   // ***************************************************
   // helper state
   // ***************************************************
   localparam int QUIET = 30 * TICK_CYC;
   logic [1:0] boot_reg, boot_next;
   logic size_reg, size_next;
   logic [15:0] quiet_reg, quiet_next;
   // boot age, mode latched at boot, time since teach input
   always_comb begin
      boot_next = (boot_reg == 2'h3) ? boot_reg : boot_reg + 2'h1;
      size_next = (boot_reg == 2'h0) ?
         config_switch_bank[bats_pkg::SW_SIZE] : size_reg;
      quiet_next = quiet_reg + {15'h0000, quiet_reg < 16'(QUIET)};
      if (teach_button || remote_teach_in) quiet_next = 16'h0000;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_reg <= 2'h0;
         size_reg <= 1'b0;
         quiet_reg <= 16'h0000;
      end else begin
         boot_reg <= boot_next;
         size_reg <= size_next;
         quiet_reg <= quiet_next;
      end
   end
   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_boot_idle;
      boot_reg == 2'h0 |-> analog_code == '0 && out_interrupted_n
         && !teach_indicator && !teach_last_step && !nv_wr;
   endproperty
   a_boot_idle: assert property (p_boot_idle)
      else $error("outputs not idle at boot");
   property p_nv_pulse;
      nv_wr |=> !nv_wr;
   endproperty
   a_nv_pulse: assert property (p_nv_pulse)
      else $error("store pulse longer than one cycle");
   property p_nv_len;
      nv_wr |-> nv_len_out == array_len;
   endproperty
   a_nv_len: assert property (p_nv_len)
      else $error("stored length differs from fitted length");
   property p_size_intr;
      boot_reg == 2'h3 && size_reg |=>
         out_interrupted_n == !(|$past(beams_blocked));
   endproperty
   a_size_intr: assert property (p_size_intr)
      else $error("size mode discrete output wrong");
   property p_code_steady;
      boot_reg == 2'h3 && quiet_reg == 16'(QUIET) && $stable(beams_blocked)
         && $past(array_len, 4) == array_len |=> $stable(analog_code);
   endproperty
   a_code_steady: assert property (p_code_steady)
      else $error("level moved with steady beams");
   property p_volt_steady;
      boot_reg == 2'h3 |-> $stable(analog_voltage_sel);
   endproperty
   a_volt_steady: assert property (p_volt_steady)
      else $error("output type changed after boot");
   property p_last_exit;
      $fell(teach_last_step) |-> ##[0:1] !teach_indicator;
   endproperty
   a_last_exit: assert property (p_last_exit)
      else $error("indicator on after teach end");
   property p_last_entry;
      $rose(teach_last_step) |-> quiet_reg < 16'(QUIET);
   endproperty
   a_last_entry: assert property (p_last_entry)
      else $error("last step entered without a press");
endmodule : bats_chk

bind bats_scaler bats_chk #(.N_BEAMS(N_BEAMS), .BW(BW), .CODE_W(CODE_W),
   .TICK_CYC(TICK_CYC)) chk (.clk, .rst_n, .beams_blocked, .array_len,
   .teach_button, .remote_teach_in, .config_switch_bank, .analog_code,
   .analog_voltage_sel, .out_interrupted_n, .teach_indicator,
   .teach_last_step, .nv_wr, .nv_len_out);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the beam array analog teach scaler
// Assumes: tick cut to 4 cycles, eight beams, 12-bit level code
// Notes: a small store model keeps references across power cycles
`timescale 1ns/1ps
module testbench;
   // ***************************************************
   // signals and models
   // ***************************************************
   localparam int LONGC = 20160;
   logic clk = 1'b0, rst_n = 1'b0, teach_button = 1'b0;
   logic remote_teach_in = 1'b0, nv_wr, out_interrupted_n;
   logic teach_indicator, teach_last_step, analog_voltage_sel, led_prev;
   logic [7:0] config_switch_bank = 8'h00, beams_blocked;
   logic [3:0] obj_lo = 4'h0, obj_hi = 4'h0, array_len = 4'h8;
   logic [3:0] nv_min_in = 4'h0, nv_max_in = 4'h8, nv_len_in = 4'h8;
   logic [3:0] nv_min_out, nv_max_out, nv_len_out;
   logic [11:0] analog_code;
   logic [31:0] seed = 32'h235f_b084;
   int mismatches = 0, samples_checked = 0, wr_cnt = 0, n;
   int mn = 0, mx = 8, size = 0, remote = 0;
   always #12.5 clk = ~clk;
   // store model: written only on the nv_wr store pulse
   always @(posedge clk) begin
      if (nv_wr) begin
         nv_min_in <= nv_min_out;
         nv_max_in <= nv_max_out;
         nv_len_in <= nv_len_out;
         wr_cnt <= wr_cnt + 1;
      end
   end
   bats_beam_model #(.N_BEAMS(8)) beams (.obj_lo, .obj_hi, .array_len,
      .beams_blocked);
   bats_scaler #(.N_BEAMS(8), .BW(4), .CODE_W(12), .TICK_CYC(4)) dut (
      .clk, .rst_n, .beams_blocked, .array_len, .teach_button,
      .remote_teach_in, .config_switch_bank, .nv_min_in, .nv_max_in,
      .nv_len_in, .analog_code, .analog_voltage_sel, .out_interrupted_n,
      .teach_indicator, .teach_last_step, .nv_wr, .nv_min_out, .nv_max_out,
      .nv_len_out);
   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // linear map, truncated and clamped to the code range
   function automatic logic [11:0] exp_code(input int v);
      int t;
      if (mn == mx) return 12'h000;
      t = (v - mn) * 4095 / (mx - mn);
      return (t < 0) ? 12'h000 : (t > 4095) ? 12'hfff : 12'(t);
   endfunction : exp_code
   task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({11'h000, got}, {11'h000, exp});
   endtask : cmp_bit
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask : cyc
   task automatic boot(input logic [7:0] sw);
      rst_n = 1'b0;
      config_switch_bank = sw;
      cyc(3);
      rst_n = 1'b1;
      cyc(3);
   endtask : boot
   task automatic press(input int k);
      if (remote != 0) remote_teach_in = 1'b1;
      else teach_button = 1'b1;
      cyc(k);
      teach_button = 1'b0;
      remote_teach_in = 1'b0;
      cyc(200);
   endtask : press
   // place an object, then check level and discrete output
   task automatic look(input int lo, input int hi);
      int v, hit;
      obj_lo = 4'(lo);
      obj_hi = 4'(hi);
      cyc(3);
      v = (lo == 0) ? 0 : (size != 0) ? hi - lo + 1 : hi;
      hit = lo != 0 && (size != 0 || (hi >= (mn < mx ? mn : mx)
         && lo <= (mn < mx ? mx : mn)));
      cmp_val(analog_code, exp_code(v));
      cmp_bit(out_interrupted_n, hit == 0);
   endtask : look
   task automatic rnd_looks();
      int a, b;
      repeat (10) begin
         seed = xs(seed);
         a = int'(seed[7:0]) % int'(array_len) + 1;
         b = int'(seed[15:8]) % int'(array_len) + 1;
         if (seed[17:16] == 2'h0) a = 0;
         look(a < b ? a : b, a < b ? b : a);
      end
   endtask : rnd_looks
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      #(98_000 * 25);
      mismatches++;
      finish_test();
   end
   initial begin
      boot(8'h00);
      cmp_bit(analog_voltage_sel, 1'b0);
      look(0, 0);
      look(8, 8);
      rnd_looks();
      config_switch_bank = 8'h01;
      cyc(4);
      cmp_bit(analog_voltage_sel, 1'b0);
      boot(8'h05);
      cmp_bit(analog_voltage_sel, 1'b1);
      remote = 1;
      press(LONGC);
      cmp_bit(teach_indicator, 1'b1);
      look(1, 1);
      press(160);
      // session minimum is live at once, maximum still the old one
      mn = 1;
      look(6, 6);
      press(160);
      mx = 6;
      cmp_bit(teach_last_step, 1'b1);
      look(3, 3);
      n = wr_cnt;
      press(LONGC);
      cmp_bit(teach_last_step, 1'b0);
      cmp_bit(teach_indicator, 1'b0);
      cmp_val(12'(wr_cnt - n), 12'h001);
      cmp_val({8'h00, nv_min_out}, 12'h001);
      cmp_val({8'h00, nv_max_out}, 12'h006);
      look(8, 8);
      look(3, 8);
      remote = 0;
      press(LONGC);
      look(6, 6);
      press(160);
      mn = 6;
      n = 0;
      repeat (12000) begin
         led_prev = teach_indicator;
         cyc(1);
         n += int'(teach_indicator & !led_prev);
      end
      cmp_val(12'(n), 12'h002);
      look(1, 1);
      press(160);
      mx = 1;
      look(3, 3);
      press(160);
      mn = 1;
      mx = 6;
      cmp_bit(teach_indicator, 1'b0);
      look(3, 3);
      press(LONGC);
      boot(8'h00);
      cmp_bit(teach_indicator, 1'b0);
      cmp_val({8'h00, nv_min_out}, 12'h001);
      look(3, 3);
      boot(8'h80);
      mn = 0;
      mx = 8;
      cmp_val({8'h00, nv_min_out}, 12'h000);
      cmp_val({8'h00, nv_max_out}, 12'h008);
      look(8, 8);
      look(0, 0);
      array_len = 4'h5;
      cyc(4);
      mx = 5;
      cmp_val({8'h00, nv_len_out}, 12'h005);
      look(5, 5);
      boot(8'h02);
      size = 1;
      look(2, 4);
      rnd_looks();
      finish_test();
   end
endmodule : testbench
